// File: rtl/crb_pkg.sv
// Contract
// - Readback permission is forbid, allow one, or allow unlimited.
// - A falling edge on the request pin starts a readback.
// - Request high plus two clock rises, then low, restarts at frame zero.
// - One new serial bit leaves at each rising configuration clock edge.
// - First start bit follows the first clock rise after request low by cycles.
// - Readback stream may be steered to another pin when the pad is TDO.
// - Before and during configuration the request pad drives disable; no readback.
// - After configuration options choose readback or disable; disable from any pin.
// - Readback works during user operation and never chains through devices.
// - The five outputs of each logic cell unit can be captured.
// - Capture modes: none, on entry, on internal signal, or either.
// - Data goes out true; each frame has one low start and one high stop bit.
// - No preamble or length count is sent in the readback stream.
// - After configuration disable is unused, from pad, or from routing.
// - Disable is active low before configuration; sense invertible after.
// - Active disable tri-states user outputs and pulls user inputs up.
// - Active disable tri-states done and data outputs; done input pulled up.
// - Request, reset and program inputs stay live with pull-ups under disable.
`default_nettype none
package crb_pkg;
  // Readback permission codes.
  typedef enum logic [1:0] {
    CRB_RB_FORBID,
    CRB_RB_ONCE,
    CRB_RB_UNLIMITED
  } crb_perm_t;
  // Capture mode codes.
  typedef enum logic [1:0] {
    CRB_CAP_NONE,
    CRB_CAP_ENTRY,
    CRB_CAP_SIGNAL,
    CRB_CAP_EITHER
  } crb_cap_t;
  // Output-disable source after configuration.
  typedef enum logic [1:0] {
    CRB_DIS_UNUSED,
    CRB_DIS_PAD,
    CRB_DIS_ROUTE
  } crb_dis_t;
  localparam int CRB_CELL_OUTS   = 5;
  localparam int CRB_LEAD_CYCLES = 4;
  localparam int CRB_RESTART_EDGES = 2;
  localparam logic CRB_START_BIT = 1'h0;
  localparam logic CRB_STOP_BIT  = 1'h1;
endpackage
`default_nettype wire

// File: rtl/crb_readback.sv
`default_nettype none
module crb_readback #(
  parameter int NUM_CELLS   = 4,
  parameter int FRAME_BITS  = 16,
  parameter int NUM_FRAMES  = 4
) (
  input  wire logic              mclk_in,
  input  wire logic              arst_n_in,
  input  wire logic              config_clock_in,
  input  wire logic              rd_request_n_in,
  input  wire logic              configured_in,
  input  wire crb_pkg::crb_perm_t perm_in,
  input  wire crb_pkg::crb_cap_t cap_mode_in,
  input  wire crb_pkg::crb_dis_t dis_src_in,
  input  wire logic              dis_invert_in,
  input  wire logic              pad_for_readback_in,
  input  wire logic              dis_pin_in,
  input  wire logic              dis_route_in,
  input  wire logic              cap_signal_n_in,
  input  wire logic              tdo_mode_in,
  input  wire logic              tdo_data_in,
  input  wire logic [NUM_CELLS*crb_pkg::CRB_CELL_OUTS-1:0] cell_outs_in,
  input  wire logic [FRAME_BITS-1:0] frame_data_in,
  output logic [$clog2(NUM_FRAMES+1)-1:0] frame_addr_out,
  output logic                   global_output_disable_out,
  output logic                   user_oe_allow_out,
  output logic                   user_pullup_out,
  output logic                   user_pulldown_en_out,
  output logic                   done_oe_allow_out,
  output logic                   done_pullup_out,
  output logic                   ctrl_pullup_out,
  output logic                   data_pad_out,
  output logic                   data_pad_oe_out,
  output logic                   alt_pin_out,
  output logic                   alt_pin_oe_out,
  output logic                   busy_out
);
  import crb_pkg::*;

  localparam int CAPW = NUM_CELLS*CRB_CELL_OUTS;
  localparam int FW   = FRAME_BITS + 2;
  localparam int BW   = $clog2(FW+1);
  localparam int AW   = $clog2(NUM_FRAMES+1);
  localparam int LW   = $clog2(CRB_LEAD_CYCLES+1);

  typedef enum logic [1:0] {
    CRB_ST_IDLE,
    CRB_ST_LEAD,
    CRB_ST_SHIFT,
    CRB_ST_HOLD
  } crb_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // Reset release and pin synchronisers.
  logic [1:0] rst_sync_reg;
  logic       rst_n;
  logic [1:0] config_clock_sync_reg;
  logic [1:0] req_sync_reg;
  logic       config_clock_d_reg;
  logic       req_d_reg;
  logic       config_clock_rise;
  logic       req_fall;

  // Reset is released through two flops.
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'h1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  // Configuration clock and request pin pass two flops before sequencer use; the disable path takes the raw request pin.
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      config_clock_sync_reg <= 2'h0;
      req_sync_reg  <= 2'h3;
      config_clock_d_reg    <= 1'h0;
      req_d_reg     <= 1'h1;
    end else begin
      config_clock_sync_reg <= {config_clock_sync_reg[0], config_clock_in};
      req_sync_reg  <= {req_sync_reg[0], rd_request_n_in};
      config_clock_d_reg    <= config_clock_sync_reg[1];
      req_d_reg     <= req_sync_reg[1];
    end
  end
  assign config_clock_rise = config_clock_sync_reg[1] & ~config_clock_d_reg;
  assign req_fall  = ~req_sync_reg[1] & req_d_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Global output disable source and sense.
  logic dis_raw;
  logic dis_active;

  // Pad always drives it before and during configuration.
  always_comb begin
    dis_raw = 1'h1;
    if (!configured_in) begin
      dis_raw = rd_request_n_in;
    end else begin
      unique case (dis_src_in)
        CRB_DIS_UNUSED: dis_raw = 1'h1;
        CRB_DIS_PAD:    dis_raw = pad_for_readback_in ? dis_pin_in
                                                      : rd_request_n_in;
        CRB_DIS_ROUTE:  dis_raw = dis_route_in;
        default:        dis_raw = 1'h1;
      endcase
    end
  end
  // Active low before configuration, invertible after.
  // An unused source never disables, whatever the selected sense.
  always_comb begin
    if (configured_in && dis_src_in == CRB_DIS_UNUSED) begin
      dis_active = 1'h0;
    end else if (configured_in && dis_invert_in) begin
      dis_active = dis_raw;
    end else begin
      dis_active = ~dis_raw;
    end
  end
  assign global_output_disable_out = dis_active;

  // Pad controls while the disable is active.
  always_comb begin
    user_oe_allow_out    = ~dis_active;
    user_pullup_out      = dis_active;
    user_pulldown_en_out = ~dis_active;
    done_oe_allow_out    = ~dis_active;
    done_pullup_out      = dis_active;
    ctrl_pullup_out      = dis_active;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Readback sequencer.
  crb_state_t      state_reg;
  logic [LW-1:0]   lead_reg;
  logic [BW-1:0]   bit_reg;
  logic [AW-1:0]   frame_reg;
  logic [FW-1:0]   shift_reg;
  logic            used_reg;
  logic            high_edges_reg;
  logic [1:0]      high_cnt_reg;
  logic            rb_allowed;
  logic            start_ok;
  logic            entry_pulse;
  logic            out_bit_reg;

  // Only the single device answers; no chained output exists.
  assign rb_allowed = configured_in && pad_for_readback_in
                      && (perm_in == CRB_RB_UNLIMITED
                          || (perm_in == CRB_RB_ONCE && !used_reg));
  assign start_ok    = req_fall && rb_allowed
                       && (state_reg == CRB_ST_IDLE);
  assign entry_pulse = start_ok;

  // Count clock rises while request is high to permit a restart.
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      high_cnt_reg <= 2'h0;
    end else if (!req_sync_reg[1]) begin
      high_cnt_reg <= 2'h0;
    end else if (config_clock_rise && high_cnt_reg != 2'(CRB_RESTART_EDGES)) begin
      high_cnt_reg <= high_cnt_reg + 2'h1;
    end
  end
  assign high_edges_reg = (high_cnt_reg == 2'(CRB_RESTART_EDGES));

  // Allow-one permission is spent once the first readback starts.
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      used_reg <= 1'h0;
    end else if (start_ok) begin
      used_reg <= 1'h1;
    end
  end

  // Frame sequencing on the synchronised clock rises.
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= CRB_ST_IDLE;
      lead_reg  <= '0;
      bit_reg   <= '0;
      frame_reg <= '0;
      shift_reg <= '1;
    end else begin
      unique case (state_reg)
        CRB_ST_IDLE: begin
          if (start_ok) begin
            state_reg <= CRB_ST_LEAD;
            lead_reg  <= '0;
            frame_reg <= '0;
          end
        end
        CRB_ST_LEAD: begin
          if (req_sync_reg[1]) begin
            state_reg <= CRB_ST_HOLD;
          end else if (config_clock_rise) begin
            if (lead_reg == LW'(CRB_LEAD_CYCLES - 1)) begin
              state_reg <= CRB_ST_SHIFT;
              // No preamble or length count precedes the frames.
              shift_reg <= {CRB_START_BIT, frame_data_in,
                            CRB_STOP_BIT};
              bit_reg   <= '0;
            end else begin
              lead_reg <= lead_reg + LW'(1);
            end
          end
        end
        CRB_ST_SHIFT: begin
          if (req_sync_reg[1]) begin
            state_reg <= CRB_ST_HOLD;
          end else if (config_clock_rise) begin
            if (bit_reg == BW'(FW - 1)) begin
              bit_reg <= '0;
              if (frame_reg == AW'(NUM_FRAMES - 1)) begin
                state_reg <= CRB_ST_HOLD;
                shift_reg <= '1;
              end else begin
                frame_reg <= frame_reg + AW'(1);
                shift_reg <= {CRB_START_BIT, frame_data_in, CRB_STOP_BIT};
              end
            end else begin
              bit_reg   <= bit_reg + BW'(1);
              shift_reg <= {shift_reg[FW-2:0], 1'h1};
            end
          end
        end
        CRB_ST_HOLD: begin
          // Restart needs request high for two clock rises.
          if (high_edges_reg) begin
            state_reg <= CRB_ST_IDLE;
          end
        end
      endcase
    end
  end
  assign frame_addr_out = (state_reg == CRB_ST_SHIFT && bit_reg == BW'(FW - 1))
                          ? frame_reg + AW'(1) : frame_reg;
  assign busy_out = (state_reg == CRB_ST_LEAD) || (state_reg == CRB_ST_SHIFT);

  // Serial bit registered, sent non-inverted.
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      out_bit_reg <= 1'h1;
    end else begin
      out_bit_reg <= (state_reg == CRB_ST_SHIFT) ? shift_reg[FW-1]
                                                 : 1'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Capture memory for logic cell unit outputs.
  logic [CAPW-1:0] cap_reg;
  logic            cap_write;

  // Signal capture writes continuously while the signal sits at zero.
  always_comb begin
    unique case (cap_mode_in)
      CRB_CAP_NONE:   cap_write = 1'h0;
      CRB_CAP_ENTRY:  cap_write = entry_pulse;
      CRB_CAP_SIGNAL: cap_write = ~cap_signal_n_in;
      CRB_CAP_EITHER: cap_write = entry_pulse | ~cap_signal_n_in;
      default:        cap_write = 1'h0;
    endcase
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CELLS; gi++) begin : g_cap
      // Each logic cell unit stores its five outputs together.
      always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
          cap_reg[gi*CRB_CELL_OUTS +: CRB_CELL_OUTS] <= '0;
        end else if (cap_write) begin
          cap_reg[gi*CRB_CELL_OUTS +: CRB_CELL_OUTS] <=
            cell_outs_in[gi*CRB_CELL_OUTS +: CRB_CELL_OUTS];
        end
      end
    end
  endgenerate

  // Capture memory reduced to one parity bit, used only by the capture cover.
  logic cap_bit;
  assign cap_bit = ^cap_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Pad routing for the data stream.
  // Shared pad carries the stream unless it serves as TDO.
  always_comb begin
    data_pad_out    = tdo_mode_in ? tdo_data_in : out_bit_reg;
    data_pad_oe_out = ~dis_active;
    alt_pin_out     = out_bit_reg;
    alt_pin_oe_out  = tdo_mode_in & ~dis_active;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  a_disable_pre_cfg: assert property (@(posedge mclk_in) disable iff (!rst_n)
    !configured_in |-> global_output_disable_out == !rd_request_n_in)
    else $error("disable not from pad before configuration");
  a_no_rb_precfg: assert property (@(posedge mclk_in) disable iff (!rst_n)
    !configured_in |-> !start_ok)
    else $error("readback started before configuration");
  a_forbid_perm: assert property (@(posedge mclk_in) disable iff (!rst_n)
    perm_in == CRB_RB_FORBID |-> !start_ok)
    else $error("readback started while forbidden");
  a_once_perm: assert property (@(posedge mclk_in) disable iff (!rst_n)
    (perm_in == CRB_RB_ONCE && used_reg) |-> !start_ok)
    else $error("second readback under allow-one");
  a_lead_start: assert property (@(posedge mclk_in) disable iff (!rst_n)
    (state_reg == CRB_ST_LEAD && $past(state_reg) == CRB_ST_IDLE)
      |-> frame_reg == '0)
    else $error("readback did not restart at frame zero");
  a_start_bit: assert property (@(posedge mclk_in) disable iff (!rst_n)
    (state_reg == CRB_ST_SHIFT && $past(state_reg) == CRB_ST_LEAD)
      |=> out_bit_reg == CRB_START_BIT)
    else $error("frame did not open with a low start bit");
  a_idle_high: assert property (@(posedge mclk_in) disable iff (!rst_n)
    $past(state_reg) != CRB_ST_SHIFT |-> out_bit_reg)
    else $error("stream not high outside frames");
  a_shift_edge: assert property (@(posedge mclk_in) disable iff (!rst_n)
    (state_reg == CRB_ST_SHIFT && !config_clock_rise && !req_sync_reg[1])
      |=> $stable(shift_reg))
    else $error("stream moved without a clock rise");
  a_tristate_out: assert property (@(posedge mclk_in) disable iff (!rst_n)
    global_output_disable_out |-> !user_oe_allow_out && !data_pad_oe_out
      && !done_oe_allow_out && ctrl_pullup_out)
    else $error("pads not released under disable");
  a_req_abort: assert property (@(posedge mclk_in) disable iff (!rst_n)
    (busy_out && req_sync_reg[1]) |=> state_reg == CRB_ST_HOLD)
    else $error("readback continued with request high");
  c_start: cover property (@(posedge mclk_in) disable iff (!rst_n) start_ok);
  c_frame: cover property (@(posedge mclk_in) disable iff (!rst_n)
    state_reg == CRB_ST_SHIFT && frame_reg == AW'(1));
  c_capture: cover property (@(posedge mclk_in) disable iff (!rst_n)
    cap_write && cap_bit);
  c_restart: cover property (@(posedge mclk_in) disable iff (!rst_n)
    state_reg == CRB_ST_HOLD ##1 state_reg == CRB_ST_IDLE);
endmodule
`default_nettype wire

// File: verification/crb_host.sv
`default_nettype none
module crb_host (
  output logic      config_clock_out,
  output logic      req_n_out,
  input  wire logic data_in
);
  timeunit 1ns;
  timeprecision 100ps;
  // Bits sampled at each falling clock edge, in the middle of the bit.
  logic got_q[$];
  // The clock stands low outside frames; the request idles high.
  initial begin
    config_clock_out = 1'b0;
    req_n_out = 1'b1;
  end
  // Gives n rising edges at the 125 ns period and samples one bit per edge.
  task automatic rises(input int n);
    repeat (n) begin
      #62.5 config_clock_out = 1'b1;
      #62.5 config_clock_out = 1'b0;
      got_q.push_back(data_in);
    end
  endtask
  // Moves the request pin and holds it until the next call.
  task automatic set_req(input logic v);
    req_n_out = v;
    #100;
  endtask
endmodule
`default_nettype wire

// File: verification/tb_config_readback_global_tristate.sv
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin miscompares++; $display("[ERR] %0t got %0b exp %0b", $time, (g), (e)); end end
module tb_config_readback_global_tristate;
  timeunit 1ns;
  timeprecision 100ps;
  import crb_pkg::*;
  localparam int FB = 8;
  localparam int NF = 2;
  logic       mclk_in = 1'b0, arst_n_in = 1'b0, configured_in = 1'b0;
  crb_perm_t  perm_in = CRB_RB_FORBID;
  crb_cap_t   cap_mode_in = CRB_CAP_NONE;
  crb_dis_t   dis_src_in = CRB_DIS_PAD;
  logic       dis_invert_in = 1'b0, pad_for_readback_in = 1'b0;
  logic       dis_pin_in = 1'b1, dis_route_in = 1'b1, cap_signal_n_in = 1'b1;
  logic       tdo_mode_in = 1'b0, tdo_data_in = 1'b0;
  logic [4:0] cell_outs_in = 5'h00;
  logic [7:0] frame_data_in = 8'h00;
  logic [7:0] frames [0:3];
  logic [1:0] faddr;
  logic       god, uoe, upu, upd, doe, dpu, cpu, pad, pad_oe, alt, alt_oe;
  logic       busy, config_clock, req_n, rb_wire, e;
  logic [31:0] lfsr_s;
  int         miscompares = 0, n_compared = 0;

  crb_readback #(.NUM_CELLS(1), .FRAME_BITS(FB), .NUM_FRAMES(NF)) dut (
    .mclk_in(mclk_in), .arst_n_in(arst_n_in), .config_clock_in(config_clock),
    .rd_request_n_in(req_n), .configured_in(configured_in),
    .perm_in(perm_in), .cap_mode_in(cap_mode_in), .dis_src_in(dis_src_in),
    .dis_invert_in(dis_invert_in), .pad_for_readback_in(pad_for_readback_in),
    .dis_pin_in(dis_pin_in), .dis_route_in(dis_route_in),
    .cap_signal_n_in(cap_signal_n_in), .tdo_mode_in(tdo_mode_in),
    .tdo_data_in(tdo_data_in), .cell_outs_in(cell_outs_in),
    .frame_data_in(frame_data_in), .frame_addr_out(faddr),
    .global_output_disable_out(god), .user_oe_allow_out(uoe),
    .user_pullup_out(upu), .user_pulldown_en_out(upd),
    .done_oe_allow_out(doe), .done_pullup_out(dpu), .ctrl_pullup_out(cpu),
    .data_pad_out(pad), .data_pad_oe_out(pad_oe), .alt_pin_out(alt),
    .alt_pin_oe_out(alt_oe), .busy_out(busy));

  crb_host host (.config_clock_out(config_clock), .req_n_out(req_n), .data_in(rb_wire));

  // The host sees the active pin; an undriven pin floats high on a pull-up.
  assign rb_wire = tdo_mode_in ? (alt_oe ? alt : 1'b1)
                               : (pad_oe ? pad : 1'b1);

  // System clock at 100 MHz.
  always #5 mclk_in = ~mclk_in;

  // Frame store answers the frame index the design asks for.
  always @(posedge mclk_in) frame_data_in <= frames[faddr];

  // Step of the pseudo-random sequence.
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Expected disable for one sweep point; bit fields follow the sweep.
  function automatic logic dis_exp(input int i);
    logic raw;
    if (!i[0]) return !i[3];
    case (i / 64)
      0: return 1'b0;
      1: raw = i[2] ? i[4] : i[3];
      default: raw = i[5];
    endcase
    return i[1] ? raw : !raw;
  endfunction

  // Pulses reset for three cycles and lets the synchroniser settle.
  task automatic apply_reset();
    @(posedge mclk_in);
    arst_n_in <= 1'b0;
    repeat (3) @(posedge mclk_in);
    arst_n_in <= 1'b1;
    repeat (4) @(posedge mclk_in);
  endtask

  // Runs one readback; a refused one must leave the line idle high.
  task automatic run_rb(input bit ok);
    bit exp_q[$];
    repeat (CRB_LEAD_CYCLES - 1) exp_q.push_back(1'b1);
    for (int f = 0; f < NF; f++) begin
      exp_q.push_back(CRB_START_BIT);
      for (int b = FB - 1; b >= 0; b--) exp_q.push_back(frames[f][b]);
      exp_q.push_back(CRB_STOP_BIT);
    end
    exp_q.push_back(1'b1);
    host.got_q.delete();
    host.set_req(1'b0);
    host.rises(CRB_LEAD_CYCLES);
    `CHK(busy, ok)
    host.rises(exp_q.size() - CRB_LEAD_CYCLES);
    host.set_req(1'b1);
    host.rises(CRB_RESTART_EDGES);
    for (int i = 0; i < exp_q.size(); i++)
      `CHK(host.got_q[i], ok ? exp_q[i] : 1'b1)
  endtask

  // Prints the verdict and ends the run.
  task automatic tally_and_finish();
    if (miscompares == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Cuts a hang short well after the expected run time.
  initial begin
    #800us;
    miscompares++;
    tally_and_finish();
  end

  // Main sequence.
  initial begin
    lfsr_s = 32'h1F6A6795;
    for (int f = 0; f < 4; f++) begin
      lfsr_s = lfsr(lfsr_s);
      frames[f] = lfsr_s[7:0];
    end
    apply_reset();
    // Sweep every disable source, sense, pin and configuration state.
    for (int i = 0; i < 192; i++) begin
      @(posedge mclk_in);
      {dis_route_in, dis_pin_in} <= i[5:4];
      {pad_for_readback_in, dis_invert_in, configured_in} <= i[2:0];
      dis_src_in <= crb_dis_t'(i / 64);
      host.set_req(i[3]);
      e = dis_exp(i);
      `CHK(god, e)
      `CHK(uoe, !e)
      `CHK(doe, !e)
      if (e) `CHK({upu, upd, dpu, cpu, pad_oe}, 5'b10110)
    end
    @(posedge mclk_in);
    {dis_src_in, dis_pin_in, dis_invert_in} <= {CRB_DIS_PAD, 2'b10};
    {pad_for_readback_in, configured_in} <= 2'b11;
    host.set_req(1'b1);
    run_rb(1'b0);
    @(posedge mclk_in);
    perm_in <= CRB_RB_UNLIMITED;
    configured_in <= 1'b0;
    run_rb(1'b0);
    @(posedge mclk_in);
    configured_in <= 1'b1;
    // Every capture mode, back to back, with unlimited permission.
    for (int m = 0; m < 4; m++) begin
      lfsr_s = lfsr(lfsr_s);
      @(posedge mclk_in);
      cap_mode_in <= crb_cap_t'(m);
      cap_signal_n_in <= lfsr_s[7];
      cell_outs_in <= lfsr_s[4:0];
      dis_route_in <= lfsr_s[11];
      run_rb(1'b1);
    end
    // Abort mid-stream, then restart from frame zero.
    host.set_req(1'b0);
    host.rises(CRB_LEAD_CYCLES + 6);
    host.set_req(1'b1);
    host.rises(CRB_RESTART_EDGES);
    run_rb(1'b1);
    // Shared pad serves test data; the stream moves to the other pin.
    @(posedge mclk_in);
    tdo_mode_in <= 1'b1;
    tdo_data_in <= lfsr_s[9];
    @(negedge mclk_in);
    `CHK(pad, tdo_data_in)
    run_rb(1'b1);
    @(posedge mclk_in);
    tdo_mode_in <= 1'b0;
    // One readback only: the second request is ignored.
    apply_reset();
    perm_in <= CRB_RB_ONCE;
    run_rb(1'b1);
    run_rb(1'b0);
    tally_and_finish();
  end
endmodule
`default_nettype wire
